// ===== logic/modem_power_control_sequencer.sv
`timescale 1ns/1ps
module modem_power_control_sequencer #(
    parameter logic [31:0] REG_READY_CYC = pwr_seq_pkg::REG_READY_CYC,
    parameter logic [31:0] ON_HOLD_CYC   = pwr_seq_pkg::ON_HOLD_CYC,
    parameter logic [31:0] OFF_HOLD_CYC  = pwr_seq_pkg::OFF_HOLD_CYC
) (
    input  wire logic ref_clk_in,               // 200 MHz clock
    input  wire logic sys_rst_in,               // Synchronous reset, active high
    input  wire logic regulator_enable_n_in,    // Enable pin, low = regulator off
    input  wire logic hard_reset_n_in,          // Hard reset pin, low = reset
    input  wire logic power_toggle_n_in,        // Power toggle pin, low = pressed
    input  wire logic inputs_driven_high_in,    // Any signal input seen high
    input  wire logic sw_power_down_in,         // Software power-down pulse
    input  wire logic detach_done_in,           // Network detach finished
    output logic      power_state_monitor_out,  // 1 = powered on
    output logic      aux_supply_out,           // Auxiliary supply enable
    output logic      regulator_ready_out,      // Regulator operational
    output logic      detach_request_out,       // Ask radio to leave network
    output logic      core_reset_out            // Hold modem core in reset
);
    import pwr_seq_pkg::*;

    logic        reg_en_f;
    logic        hard_rst_n_f;
    logic        toggle_n_f;
    logic        inputs_high_f;
    logic        toggle_prev_q;
    logic        toggle_rel;
    logic [31:0] press_cnt_q;
    logic [31:0] reg_cnt_q;
    logic        reg_ready_q;
    logic        reg_ready_d;
    state_type   state_q;
    state_type   state_d;
    logic        monitor_q;
    logic        aux_q;
    logic        detach_q;
    logic        core_rst_q;

    // ==================================================================
    // Decoding
    function automatic logic is_powered(input state_type s);
        return s != ST_OFF;
    endfunction : is_powered

    // ==================================================================
    // Pin conditioning
    pin_filter #(.IDLE_LEVEL(PIN_IDLE_HIGH)) u_en_filt (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (regulator_enable_n_in),
        .level_out  (reg_en_f)
    );
    pin_filter #(.IDLE_LEVEL(PIN_IDLE_HIGH)) u_rst_filt (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (hard_reset_n_in),
        .level_out  (hard_rst_n_f)
    );
    pin_filter #(.IDLE_LEVEL(PIN_IDLE_HIGH)) u_tog_filt (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (power_toggle_n_in),
        .level_out  (toggle_n_f)
    );
    pin_filter #(.IDLE_LEVEL(PIN_IDLE_LOW)) u_in_filt (
        .ref_clk_in (ref_clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (inputs_driven_high_in),
        .level_out  (inputs_high_f)
    );

    // ==================================================================
    // Regulator start-up delay
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || !reg_en_f) begin
            reg_cnt_q <= 32'h0000_0000;
        end else if (reg_cnt_q != REG_READY_CYC) begin
            reg_cnt_q <= reg_cnt_q + 32'h0000_0001;
        end
    end

    assign reg_ready_d = reg_en_f && (reg_cnt_q == REG_READY_CYC - 32'h0000_0001 || reg_ready_q);

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            reg_ready_q <= 1'b0;
        end else begin
            reg_ready_q <= reg_ready_d;
        end
    end

    // ==================================================================
    // Toggle press length
    assign toggle_rel = toggle_n_f && !toggle_prev_q;

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            toggle_prev_q <= 1'b1;
            press_cnt_q   <= 32'h0000_0000;
        end else begin
            toggle_prev_q <= toggle_n_f;
            if (toggle_n_f || !reg_ready_q) begin
                press_cnt_q <= 32'h0000_0000;
            end else if (press_cnt_q != CNT_MAX) begin
                press_cnt_q <= press_cnt_q + 32'h0000_0001;
            end
        end
    end

    // ==================================================================
    // Power state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_OFF: begin
                if (reg_ready_q && toggle_rel && press_cnt_q >= ON_HOLD_CYC) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (reg_ready_q && toggle_rel && press_cnt_q >= OFF_HOLD_CYC) begin
                    state_d = ST_DETACH;
                end else if (reg_ready_q && sw_power_down_in) begin
                    state_d = ST_DETACH;
                end
            end
            ST_DETACH: begin
                if (detach_done_in) begin
                    state_d = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!inputs_high_f) begin
                    state_d = ST_OFF;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (!reg_en_f) begin
            state_d = ST_OFF;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // ==================================================================
    // Outputs
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            monitor_q  <= 1'b0;
            aux_q      <= 1'b0;
            detach_q   <= 1'b0;
            core_rst_q <= 1'b1;
        end else begin
            monitor_q  <= is_powered(state_d);
            aux_q      <= is_powered(state_d);
            detach_q   <= state_d == ST_DETACH;
            core_rst_q <= !reg_ready_d || !is_powered(state_d) || !hard_rst_n_f;
        end
    end

    assign power_state_monitor_out = monitor_q;
    assign aux_supply_out          = aux_q;
    assign regulator_ready_out     = reg_ready_q;
    assign detach_request_out      = detach_q;
    assign core_reset_out          = core_rst_q;

    // ==================================================================
    // Checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    reg_delay_a: assert property ($rose(reg_ready_q) |->
        $past(reg_cnt_q) == REG_READY_CYC - 32'h0000_0001 && $past(reg_en_f))
        else $error("regulator ready before start-up delay");
    reg_loss_a: assert property (!reg_en_f |=> !reg_ready_q && !monitor_q)
        else $error("power kept after regulator disable");
    on_release_a: assert property ($rose(monitor_q) |->
        $past(toggle_rel && press_cnt_q >= ON_HOLD_CYC))
        else $error("power-on not caused by a long toggle release");
    mon_state_a: assert property ((state_q == ST_OFF) == !monitor_q)
        else $error("monitor disagrees with power state");
    detach_first_a: assert property ($fell(monitor_q) && $past(reg_en_f) |->
        $past(state_q == ST_DRAIN) ##0 $past(state_q, 2) != ST_ON)
        else $error("power-down without network detach");
    sw_down_a: assert property (state_q == ST_ON && reg_ready_q && reg_en_f &&
        sw_power_down_in |=> detach_request_out && state_q == ST_DETACH)
        else $error("software power-down not started");
    drain_hold_a: assert property (state_q == ST_DRAIN && inputs_high_f && reg_en_f
        |=> monitor_q && aux_q)
        else $error("monitor fell while inputs driven high");
    aux_follow_a: assert property (aux_q == monitor_q)
        else $error("auxiliary supply differs from monitor");
    off_release_a: assert property ($rose(detach_q) |->
        $past(reg_ready_q && (sw_power_down_in || toggle_rel && press_cnt_q >= OFF_HOLD_CYC)))
        else $error("power-down not caused by release or software request");
    on_hold_a: assert property (!toggle_n_f && state_q == ST_OFF |=> state_q == ST_OFF)
        else $error("power-on while toggle still held");
    off_hold_a: assert property (!toggle_n_f && !sw_power_down_in && state_q == ST_ON
        |=> state_q != ST_DETACH)
        else $error("power-down while toggle still held");
    detach_clear_a: assert property (state_q == ST_DETACH && detach_done_in && reg_en_f
        |=> !detach_q && state_q == ST_DRAIN && monitor_q)
        else $error("detach completion not handled");
    rst_keep_a: assert property (!hard_rst_n_f && reg_en_f && monitor_q &&
        state_q != ST_DRAIN |=> monitor_q && core_rst_q)
        else $error("hard reset changed power state");

    power_on_c: cover property ($rose(monitor_q));
    power_off_c: cover property (state_q == ST_DRAIN ##1 state_q == ST_OFF);
    sw_down_c: cover property (state_q == ST_ON && sw_power_down_in ##1 detach_q);
    hard_rst_c: cover property (monitor_q && !hard_rst_n_f ##1 core_rst_q);
    reg_cycle_c: cover property (monitor_q && !reg_en_f ##1 !reg_ready_q);

endmodule : modem_power_control_sequencer

// ===== logic/pwr_seq_pkg.sv
// Behaviour
// - Regulator counts as operational 2 ms after enable returns high.
// - Power state changes on release of the toggle pulse, not its start.
// - Power state monitor is 0 when powered down, 1 when powered on.
// - Toggle power-down notifies the network before communication stops.
// - A software command performs the same power-down as the toggle.
// - Monitor does not fall while any signal input is driven high, except when the regulator enable goes low.
// - Auxiliary supply is on while the monitor is high, off while low.
package pwr_seq_pkg;

    // ==================================================================
    // Clock and timing
    localparam int unsigned CLK_KHZ       = 200_000;
    localparam int unsigned REG_READY_MS  = 2;
    localparam int unsigned ON_HOLD_S     = 5;
    localparam int unsigned OFF_HOLD_S    = 3;
    localparam logic [31:0] REG_READY_CYC = 32'(CLK_KHZ * REG_READY_MS);
    localparam logic [31:0] ON_HOLD_CYC   = 32'(CLK_KHZ * 1000 * ON_HOLD_S);
    localparam logic [31:0] OFF_HOLD_CYC  = 32'(CLK_KHZ * 1000 * OFF_HOLD_S);
    localparam logic [31:0] CNT_MAX       = 32'hFFFF_FFFF;

    // ==================================================================
    // Reset values
    localparam logic PIN_IDLE_HIGH = 1'b1;
    localparam logic PIN_IDLE_LOW  = 1'b0;

    // ==================================================================
    // Power states
    typedef enum logic [3:0] {
        ST_OFF    = 4'b0001,
        ST_ON     = 4'b0010,
        ST_DETACH = 4'b0100,
        ST_DRAIN  = 4'b1000
    } state_type;

endpackage : pwr_seq_pkg

// ===== logic/pin_filter.sv
`timescale 1ns/1ps
module pin_filter #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input  wire logic ref_clk_in,  // 200 MHz clock
    input  wire logic sys_rst_in,  // Synchronous reset, active high
    input  wire logic pin_in,      // Asynchronous pin level
    output logic      level_out    // Filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // ==================================================================
    // Three stages; a change counts once stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            s1_q    <= IDLE_LEVEL;
            s2_q    <= IDLE_LEVEL;
            s3_q    <= IDLE_LEVEL;
            level_q <= IDLE_LEVEL;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end

    assign level_out = level_q;

endmodule : pin_filter

// ===== verif/host_model.sv
`timescale 1ns/1ps
module host_model #(
    parameter int EN_LOW_CYC = 10,
    parameter int HR_LOW_CYC = 40
) (
    input  wire logic ref_clk_in,              // Bench clock
    input  wire logic power_state_monitor_in,  // Modem power state
    output logic      regulator_enable_n_out,  // Open-drain enable pin
    output logic      hard_reset_n_out,        // Open-drain reset pin
    output logic      power_toggle_n_out       // Open-drain toggle pin
);
    logic en_low_q  = 1'b0;
    logic hr_low_q  = 1'b0;
    logic tog_low_q = 1'b0;
    // ==================================================================
    // Pins: released lines are driven high by this model's assigns
    assign regulator_enable_n_out = !en_low_q;
    assign hard_reset_n_out       = !hr_low_q;
    assign power_toggle_n_out     = !tog_low_q;
    // ==================================================================
    // Sequences
    task automatic press(input int n);
        @(posedge ref_clk_in) tog_low_q <= 1'b1;
        repeat (n) @(posedge ref_clk_in);
        tog_low_q <= 1'b0;
    endtask : press
    task automatic reg_cycle();
        @(posedge ref_clk_in) en_low_q <= 1'b1;
        repeat (EN_LOW_CYC) @(posedge ref_clk_in);
        en_low_q <= 1'b0;
    endtask : reg_cycle
    task automatic hard_reset();
        @(posedge ref_clk_in) hr_low_q <= 1'b1;
        repeat (HR_LOW_CYC) @(posedge ref_clk_in);
        hr_low_q <= 1'b0;
    endtask : hard_reset
    task automatic await_state(input logic want, output logic ok);
        int k;
        ok = 1'b0;
        for (k = 0; k < 16 && !ok; k++) begin
            @(posedge ref_clk_in);
            ok = (power_state_monitor_in === want);
        end
    endtask : await_state
endmodule : host_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    import pwr_seq_pkg::*;
    localparam int REG_CYC = 20;
    localparam int ON_CYC  = 50;
    localparam int OFF_CYC = 30;
    logic        ref_clk_in    = 1'b0;
    logic        sys_rst_in    = 1'b1;
    logic        inputs_high_q = 1'b0;
    logic        sw_down_q     = 1'b0;
    logic        done_q        = 1'b0;
    wire logic   en_n, hr_n, tog_n;
    logic        mon, aux, ready, det_req, core_rst, ok;
    int          failures        = 0;
    int          samples_checked = 0;
    int          n, len;
    logic [31:0] lfsr = 32'hFB80;

    initial forever #2.5 ref_clk_in = !ref_clk_in;

    host_model host (.ref_clk_in(ref_clk_in), .power_state_monitor_in(mon),
        .regulator_enable_n_out(en_n), .hard_reset_n_out(hr_n), .power_toggle_n_out(tog_n));
    modem_power_control_sequencer #(.REG_READY_CYC(32'(REG_CYC)), .ON_HOLD_CYC(32'(ON_CYC)),
        .OFF_HOLD_CYC(32'(OFF_CYC))) dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .regulator_enable_n_in(en_n), .hard_reset_n_in(hr_n), .power_toggle_n_in(tog_n),
        .inputs_driven_high_in(inputs_high_q), .sw_power_down_in(sw_down_q),
        .detach_done_in(done_q), .power_state_monitor_out(mon), .aux_supply_out(aux),
        .regulator_ready_out(ready), .detach_request_out(det_req), .core_reset_out(core_rst));

    // ==================================================================
    // Helpers
    task automatic check(input string what, input logic seen, input logic exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next
    function automatic logic toggles(input logic on, input int plen);
        return on ? (plen >= OFF_CYC) : (plen >= ON_CYC);
    endfunction : toggles
    task automatic cycles(input int k);
        repeat (k) @(posedge ref_clk_in);
    endtask : cycles
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    // Signal inputs stay low while switching on
    task automatic power_on(input int plen);
        inputs_high_q <= 1'b0;
        fork
            host.press(plen);
            begin
                cycles(plen - 2);
                check("monitor while held", mon, 1'b0);
            end
        join
        host.await_state(1'b1, ok);
        check("monitor reached on", ok, 1'b1);
        cycles(1);
        check("aux on", aux, 1'b1);
        check("core reset released", core_rst, 1'b0);
    endtask : power_on
    task automatic power_off(input logic by_sw, input int plen);
        inputs_high_q <= 1'b1;
        if (by_sw) begin
            @(posedge ref_clk_in) sw_down_q <= 1'b1;
            @(posedge ref_clk_in) sw_down_q <= 1'b0;
        end else begin
            fork
                host.press(plen);
                begin
                    cycles(plen - 2);
                    check("detach while held", det_req, 1'b0);
                end
            join
        end
        cycles(8);
        check("detach requested", det_req, 1'b1);
        check("monitor during detach", mon, 1'b1);
        done_q <= 1'b1;
        cycles(1);
        done_q <= 1'b0;
        cycles(12);
        check("detach cleared", det_req, 1'b0);
        check("monitor held by input", mon, 1'b1);
        check("aux held by input", aux, 1'b1);
        inputs_high_q <= 1'b0;
        host.await_state(1'b0, ok);
        check("monitor reached off", ok, 1'b1);
        cycles(1);
        check("aux off", aux, 1'b0);
        check("core reset held", core_rst, 1'b1);
    endtask : power_off

    // ==================================================================
    // Tests
    initial begin
        cycles(4);
        sys_rst_in <= 1'b0;
        cycles(1);
        check("monitor after reset", mon, 1'b0);
        check("aux after reset", aux, 1'b0);
        for (n = 0; ready !== 1'b1 && n < 100; n++) cycles(1);
        check("ready after reset", n >= REG_CYC && n <= REG_CYC + 8, 1'b1);
        host.press(ON_CYC - 1);
        cycles(8);
        check("short press ignored", mon, 1'b0);
        power_on(ON_CYC);
        host.press(OFF_CYC - 1);
        cycles(8);
        check("short off press ignored", det_req, 1'b0);
        power_off(1'b0, OFF_CYC);
        power_on(ON_CYC + 7);
        power_off(1'b1, 0);
        $display("test press and detach done");
        power_on(ON_CYC);
        fork
            host.hard_reset();
            begin
                cycles(20);
                check("core reset on pin", core_rst, 1'b1);
            end
        join
        cycles(8);
        check("power kept over hard reset", mon, 1'b1);
        check("core reset after pin", core_rst, 1'b0);
        fork
            host.reg_cycle();
            begin
                cycles(8);
                check("monitor on regulator loss", mon, 1'b0);
            end
        join
        for (n = 0; ready !== 1'b1 && n < 100; n++) cycles(1);
        check("regulator ready delay", n >= REG_CYC && n <= REG_CYC + 8, 1'b1);
        $display("test resets done");
        repeat (12) begin
            lfsr = lfsr_next(lfsr);
            len = 20 + int'(lfsr % 45);
            if (toggles(mon, len) && mon === 1'b1) power_off(lfsr[3], len);
            else if (toggles(mon, len)) power_on(len);
            else begin
                ok = mon;
                host.press(len);
                cycles(8);
                check("random press ignored", mon, ok);
                check("random no detach", det_req, 1'b0);
            end
        end
        $display("test random presses done");
        end_of_test();
    end

    initial begin
        cycles(20000);
        failures++;
        $display("watchdog expired");
        end_of_test();
    end
endmodule : testbench
